// ### hw/cod_decoder.sv
module cod_decoder
(
   input wire logic clk, // cpu clock
   input wire logic sys_rst, // synchronous reset
   input wire logic inByteValid, // a fetched byte is offered
   input wire logic [7:0] inByte, // fetched instruction byte
   output cod_pkg::cod_op_t decOp, // decoded operation
   output logic decValid, // one-cycle pulse, decode complete
   output logic decIllegal, // one-cycle pulse, byte not decodable here
   output logic decWord, // 1 word operand, 0 byte operand
   output logic decRegIsDest, // register field names the destination
   output logic [1:0] decMode, // addressing form field
   output logic [2:0] decReg, // register selector field
   output logic [2:0] decRm, // operand locator field
   output logic [15:0] decDisp, // displacement, sign-extended if 8-bit
   output logic [15:0] decImm, // immediate operand
   output logic decImmWidened // immediate came from one extended byte
);
   import cod_pkg::*;

   cod_regs_t state_r;
   cod_regs_t state_nxt;
   cod_op_t fbOp;
   logic fbKnown;
   logic fbNeedMode;
   logic fbUseDir;
   logic fbGrpArith;
   logic fbNeedConst;
   logic fbAccImm;
   logic fbWordFromBit;
   logic fbFixedWord;
   logic fbFixedDest;

   cod_first_byte u_first
   (
      .firstByte(inByte),
      .opClass(fbOp),
      .known(fbKnown),
      .needMode(fbNeedMode),
      .useDirBit(fbUseDir),
      .grpArith(fbGrpArith),
      .grpMulDiv(),
      .needConst(fbNeedConst),
      .accImm(fbAccImm),
      .wordFromBit(fbWordFromBit),
      .fixedWord(fbFixedWord),
      .fixedDest(fbFixedDest)
   );

   always_comb
   begin
      logic [1:0] md;
      logic [2:0] rs;
      logic [2:0] rm;
      logic dispAny;
      logic subBad;
      md = inByte[COD_MOD_LSB +: 2];
      rs = inByte[COD_REG_LSB +: 3];
      rm = inByte[COD_RM_LSB +: 3];
      dispAny = 1'b0;
      subBad = 1'b0;
      state_nxt = state_r;
      state_nxt.valid = 1'b0;
      state_nxt.illegal = 1'b0;
      if (inByteValid)
      begin
         case (state_r.st)
            ST_IDLE:
            begin
               state_nxt.op = fbOp;
               state_nxt.word = fbWordFromBit ? inByte[COD_W_BIT] : fbFixedWord;
               state_nxt.regIsDest = fbUseDir ? inByte[COD_D_BIT] : fbFixedDest;
               state_nxt.mode = 2'b00;
               state_nxt.regSel = 3'b000;
               state_nxt.rmSel = 3'b000;
               state_nxt.disp = 16'h0000;
               state_nxt.imm = 16'h0000;
               state_nxt.widened = 1'b0;
               state_nxt.hasImm = fbGrpArith;
               // accumulator forms take a second byte when w is 1
               state_nxt.immTwo = fbGrpArith ? (inByte[COD_S_BIT:COD_W_BIT] == 2'b01)
                                             : inByte[COD_W_BIT];
               state_nxt.widened = fbGrpArith && (inByte[COD_S_BIT:COD_W_BIT] == 2'b11);
               if (!fbKnown)
                  state_nxt.illegal = 1'b1;
               else if (fbNeedConst)
                  state_nxt.st = ST_CONST;
               else if (fbNeedMode)
                  state_nxt.st = ST_MODE;
               else if (fbAccImm)
                  state_nxt.st = ST_IMM_LO;
               else
                  state_nxt.valid = 1'b1;
            end
            ST_MODE:
            begin
               state_nxt.mode = md;
               state_nxt.regSel = rs;
               state_nxt.rmSel = rm;
               // group bytes leave op at none until this byte names it; hasImm marks the immediate group
               if (state_r.hasImm)
               begin
                  case (rs)
                     3'b000: state_nxt.op = OP_SUM;
                     3'b010: state_nxt.op = OP_CARRY_SUM;
                     3'b101: state_nxt.op = OP_DIFFERENCE;
                     3'b011: state_nxt.op = OP_BORROW_DIFF;
                     3'b111: state_nxt.op = OP_COMPARE;
                     default: subBad = 1'b1;
                  endcase
               end
               else if (state_r.op == OP_NONE)
               begin
                  case (rs)
                     3'b100: state_nxt.op = OP_UNSIGNED_PRODUCT;
                     3'b101: state_nxt.op = OP_SIGNED_PRODUCT;
                     3'b110: state_nxt.op = OP_UNSIGNED_QUOTIENT;
                     3'b111: state_nxt.op = OP_SIGNED_QUOTIENT;
                     default: subBad = 1'b1;
                  endcase
               end
               dispAny = (md == COD_MOD_DISP8) || (md == COD_MOD_DISP16)
                         || ((md == COD_MOD_NO_DISP) && (rm == COD_RM_DIRECT));
               state_nxt.dispTwo = (md != COD_MOD_DISP8);
               // other group sub-fields are refused with an illegal pulse and a return to ST_IDLE
               if (subBad)
               begin
                  state_nxt.illegal = 1'b1;
                  state_nxt.st = ST_IDLE;
               end
               else if (dispAny)
                  state_nxt.st = ST_DISP_LO;
               else if (state_r.hasImm)
                  state_nxt.st = ST_IMM_LO;
               else
               begin
                  state_nxt.valid = 1'b1;
                  state_nxt.st = ST_IDLE;
               end
            end
            ST_DISP_LO:
            begin
               state_nxt.disp = {{8{inByte[7]}}, inByte};
               if (state_r.dispTwo)
                  state_nxt.st = ST_DISP_HI;
               else if (state_r.hasImm)
                  state_nxt.st = ST_IMM_LO;
               else
               begin
                  state_nxt.valid = 1'b1;
                  state_nxt.st = ST_IDLE;
               end
            end
            ST_DISP_HI:
            begin
               state_nxt.disp[15:8] = inByte;
               if (state_r.hasImm)
                  state_nxt.st = ST_IMM_LO;
               else
               begin
                  state_nxt.valid = 1'b1;
                  state_nxt.st = ST_IDLE;
               end
            end
            ST_IMM_LO:
            begin
               state_nxt.imm = state_r.widened ? {{8{inByte[7]}}, inByte} : {8'h00, inByte};
               if (state_r.immTwo)
                  state_nxt.st = ST_IMM_HI;
               else
               begin
                  state_nxt.valid = 1'b1;
                  state_nxt.st = ST_IDLE;
               end
            end
            ST_IMM_HI:
            begin
               state_nxt.imm[15:8] = inByte;
               state_nxt.valid = 1'b1;
               state_nxt.st = ST_IDLE;
            end
            ST_CONST:
            begin
               // a wrong base byte is flagged rather than decoded as another base
               state_nxt.valid = (inByte == COD_ADJ_BASE_BYTE);
               state_nxt.illegal = (inByte != COD_ADJ_BASE_BYTE);
               state_nxt.st = ST_IDLE;
            end
            default:
               state_nxt.st = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state_r <= COD_REGS_RST;
      else
         state_r <= state_nxt;
   end

   assign decOp = state_r.op;
   assign decValid = state_r.valid;
   assign decIllegal = state_r.illegal;
   assign decWord = state_r.word;
   assign decRegIsDest = state_r.regIsDest;
   assign decMode = state_r.mode;
   assign decReg = state_r.regSel;
   assign decRm = state_r.rmSel;
   assign decDisp = state_r.disp;
   assign decImm = state_r.imm;
   assign decImmWidened = state_r.widened;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic idleIn;
   assign idleIn = inByteValid && (state_r.st == ST_IDLE);

   a_lookup_single: assert property (idleIn && inByte == 8'hD7 |=> decValid && decOp == OP_TABLE_LOOKUP)
      else $error("table lookup not decoded in one byte");
   a_flag_image: assert property (idleIn && inByte == 8'h9F |=> decValid && decOp == OP_FLAGS_TO_HIGH)
      else $error("flags to high accumulator not decoded");
   a_acc_byte_imm: assert property ((idleIn && inByte == 8'h04) ##1 inByteValid
      |=> decValid && decOp == OP_SUM && !decWord)
      else $error("byte accumulator sum wrong");
   a_acc_word_imm: assert property ((idleIn && inByte == 8'h05) ##1 inByteValid |=> !decValid)
      else $error("word accumulator immediate ended after one byte");
   a_widen_sign: assert property (decValid && decImmWidened |-> decWord && decImm[15:8] == {8{decImm[7]}})
      else $error("widened immediate not sign-extended");
   a_dir_dest: assert property ((idleIn && inByte == 8'h03) ##1 (inByteValid && inByte[7:6] == 2'b11)
      |=> decValid && decRegIsDest && decWord)
      else $error("direction or size bit lost");
   a_grp_compare: assert property ((idleIn && inByte == 8'h80) ##1 (inByteValid && inByte == 8'hF8)
      ##1 inByteValid |=> decValid && decOp == OP_COMPARE)
      else $error("immediate compare not decoded");
   a_adj_product: assert property ((idleIn && inByte == 8'hD4) ##1 (inByteValid && inByte == 8'h0A)
      |=> decValid && decOp == OP_ASCII_PRODUCT)
      else $error("ascii fix after product not decoded");
   a_adj_quotient: assert property ((idleIn && inByte == 8'hD5) ##1 (inByteValid && inByte == 8'h0A)
      |=> decValid && decOp == OP_ASCII_QUOTIENT)
      else $error("ascii fix before quotient not decoded");
   a_mul_sub: assert property ((idleIn && inByte == 8'hF6) ##1 (inByteValid && inByte == 8'hE0)
      |=> decValid && decOp == OP_UNSIGNED_PRODUCT && !decWord)
      else $error("unsigned product not decoded");
   a_div_sub: assert property ((idleIn && inByte == 8'hF7) ##1 (inByteValid && inByte == 8'hF8)
      |=> decValid && decOp == OP_SIGNED_QUOTIENT && decWord)
      else $error("signed quotient not decoded");
   a_ea_fields: assert property ((idleIn && inByte == 8'h8D) ##1 (inByteValid && inByte[7:6] == 2'b10)
      ##1 inByteValid ##1 inByteValid |=> decValid && decOp == OP_EA_LOAD && decRegIsDest && decWord)
      else $error("effective address load not decoded");
   a_far_data: assert property ((idleIn && inByte == 8'hC5) ##1 (inByteValid && inByte[7:6] == 2'b01)
      ##1 inByteValid |=> decValid && decOp == OP_FAR_DATA_SEG && decRegIsDest)
      else $error("far pointer load to data segment not decoded");
   a_far_extra: assert property ((idleIn && inByte == 8'hC4) ##1 (inByteValid && inByte == 8'h06)
      ##1 inByteValid ##1 inByteValid |=> decValid && decOp == OP_FAR_EXTRA_SEG)
      else $error("far pointer load to extra segment not decoded");
   a_carry_reg: assert property ((idleIn && inByte == 8'h13) ##1 (inByteValid && inByte[7:6] == 2'b11)
      |=> decValid && decOp == OP_CARRY_SUM && decWord && decRegIsDest)
      else $error("register carry sum not decoded");
   a_diff_acc: assert property ((idleIn && inByte == 8'h2D) ##1 inByteValid ##1 inByteValid
      |=> decValid && decOp == OP_DIFFERENCE && decWord)
      else $error("word accumulator difference not decoded");
   a_borrow_acc: assert property ((idleIn && inByte == 8'h1D) ##1 inByteValid ##1 inByteValid
      |=> decValid && decOp == OP_BORROW_DIFF && decWord)
      else $error("word accumulator borrow difference not decoded");
   a_ascii_sum: assert property (idleIn && inByte == 8'h37 |=> decValid && decOp == OP_ASCII_SUM)
      else $error("ascii fix after sum not decoded");
   a_ascii_diff: assert property (idleIn && inByte == 8'h3F |=> decValid && decOp == OP_ASCII_DIFF)
      else $error("ascii fix after difference not decoded");
   a_decimal_diff: assert property (idleIn && inByte == 8'h2F |=> decValid && decOp == OP_DECIMAL_DIFF)
      else $error("decimal fix after difference not decoded");
   a_sign_byte: assert property (idleIn && inByte == 8'h98 |=> decValid && decOp == OP_BYTE_TO_WORD)
      else $error("byte to word sign extension not decoded");
   a_sign_word: assert property (idleIn && inByte == 8'h99 |=> decValid && decOp == OP_WORD_TO_DOUBLE && decWord)
      else $error("word to double sign extension not decoded");
   // bytes outside this decoder's set must be flagged, never passed on as a decode
   a_unknown_first: assert property (idleIn && inByte == 8'hF4 |=> decIllegal && !decValid)
      else $error("unknown first byte not refused");
   a_pulse_excl: assert property (!(decValid && decIllegal))
      else $error("valid and illegal together");

   c_group_imm: cover property (decValid && decImmWidened);
   c_disp_word: cover property (decValid && decMode == COD_MOD_DISP16);
   c_quotient: cover property (decValid && decOp == OP_ASCII_QUOTIENT);
   c_muldiv: cover property (decValid && decOp == OP_SIGNED_QUOTIENT);
   c_illegal: cover property (decIllegal);

endmodule : cod_decoder

// ### hw/cod_first_byte.sv
module cod_first_byte
(
   input wire logic [7:0] firstByte, // first instruction byte
   output cod_pkg::cod_op_t opClass, // operation for fixed forms
   output logic known, // byte belongs to this decoder
   output logic needMode, // a mode byte follows
   output logic useDirBit, // d bit picks the register role
   output logic grpArith, // immediate group, sub-field picks op
   output logic grpMulDiv, // multiply/divide group
   output logic needConst, // a fixed base byte follows
   output logic accImm, // immediate-to-accumulator form
   output logic wordFromBit, // w bit picks the operand size
   output logic fixedWord, // size when there is no w bit
   output logic fixedDest // register role when there is no d bit
);
   import cod_pkg::*;

   always_comb
   begin
      opClass = OP_NONE;
      known = 1'b1;
      needMode = 1'b0;
      useDirBit = 1'b0;
      grpArith = 1'b0;
      grpMulDiv = 1'b0;
      needConst = 1'b0;
      accImm = 1'b0;
      wordFromBit = 1'b0;
      fixedWord = 1'b0;
      fixedDest = 1'b0;
      casez (firstByte)
         COD_B_TABLE_LOOKUP: opClass = OP_TABLE_LOOKUP;
         COD_B_EA_LOAD:
         begin
            opClass = OP_EA_LOAD;
            needMode = 1'b1;
            fixedWord = 1'b1;
            fixedDest = 1'b1;
         end
         COD_B_FAR_DATA_SEG, COD_B_FAR_EXTRA_SEG:
         begin
            opClass = firstByte[0] ? OP_FAR_DATA_SEG : OP_FAR_EXTRA_SEG;
            needMode = 1'b1;
            fixedWord = 1'b1;
            fixedDest = 1'b1;
         end
         COD_B_FLAGS_TO_HIGH: opClass = OP_FLAGS_TO_HIGH;
         COD_B_HIGH_TO_FLAGS: opClass = OP_HIGH_TO_FLAGS;
         COD_B_FLAGS_SAVE, COD_B_FLAGS_RESTORE:
         begin
            opClass = firstByte[0] ? OP_FLAGS_RESTORE : OP_FLAGS_SAVE;
            fixedWord = 1'b1;
         end
         8'b0000_00??, 8'b0001_00??, 8'b0010_10??, 8'b0001_10??, 8'b0011_10??:
         begin
            // register/memory with register forms
            case (firstByte[5:3])
               3'b000: opClass = OP_SUM;
               3'b010: opClass = OP_CARRY_SUM;
               3'b101: opClass = OP_DIFFERENCE;
               3'b011: opClass = OP_BORROW_DIFF;
               default: opClass = OP_COMPARE;
            endcase
            needMode = 1'b1;
            useDirBit = 1'b1;
            wordFromBit = 1'b1;
         end
         8'b0000_010?, 8'b0001_010?, 8'b0010_110?, 8'b0001_110?, 8'b0011_110?:
         begin
            case (firstByte[5:3])
               3'b000: opClass = OP_SUM;
               3'b010: opClass = OP_CARRY_SUM;
               3'b101: opClass = OP_DIFFERENCE;
               3'b011: opClass = OP_BORROW_DIFF;
               default: opClass = OP_COMPARE;
            endcase
            accImm = 1'b1;
            wordFromBit = 1'b1;
         end
         8'b1000_00??:
         begin
            grpArith = 1'b1;
            needMode = 1'b1;
            wordFromBit = 1'b1;
         end
         8'b1111_011?:
         begin
            grpMulDiv = 1'b1;
            needMode = 1'b1;
            wordFromBit = 1'b1;
         end
         COD_B_ASCII_SUM: opClass = OP_ASCII_SUM;
         COD_B_DECIMAL_SUM: opClass = OP_DECIMAL_SUM;
         COD_B_ASCII_DIFF: opClass = OP_ASCII_DIFF;
         COD_B_DECIMAL_DIFF: opClass = OP_DECIMAL_DIFF;
         COD_B_ASCII_PRODUCT, COD_B_ASCII_QUOTIENT:
         begin
            opClass = firstByte[0] ? OP_ASCII_QUOTIENT : OP_ASCII_PRODUCT;
            needConst = 1'b1;
         end
         COD_B_BYTE_TO_WORD: opClass = OP_BYTE_TO_WORD;
         COD_B_WORD_TO_DOUBLE:
         begin
            opClass = OP_WORD_TO_DOUBLE;
            fixedWord = 1'b1;
         end
         default: known = 1'b0;
      endcase
   end

endmodule : cod_first_byte

// ### hw/cod_pkg.sv
package cod_pkg;

   // first-byte encodings
   localparam logic [7:0] COD_B_TABLE_LOOKUP = 8'hD7;
   localparam logic [7:0] COD_B_EA_LOAD = 8'h8D;
   localparam logic [7:0] COD_B_FAR_DATA_SEG = 8'hC5;
   localparam logic [7:0] COD_B_FAR_EXTRA_SEG = 8'hC4;
   localparam logic [7:0] COD_B_FLAGS_TO_HIGH = 8'h9F;
   localparam logic [7:0] COD_B_HIGH_TO_FLAGS = 8'h9E;
   localparam logic [7:0] COD_B_FLAGS_SAVE = 8'h9C;
   localparam logic [7:0] COD_B_FLAGS_RESTORE = 8'h9D;
   localparam logic [7:0] COD_B_ASCII_SUM = 8'h37;
   localparam logic [7:0] COD_B_DECIMAL_SUM = 8'h27;
   localparam logic [7:0] COD_B_ASCII_DIFF = 8'h3F;
   localparam logic [7:0] COD_B_DECIMAL_DIFF = 8'h2F;
   localparam logic [7:0] COD_B_ASCII_PRODUCT = 8'hD4;
   localparam logic [7:0] COD_B_ASCII_QUOTIENT = 8'hD5;
   localparam logic [7:0] COD_B_BYTE_TO_WORD = 8'h98;
   localparam logic [7:0] COD_B_WORD_TO_DOUBLE = 8'h99;
   // second byte that must follow the two-byte ascii adjusts
   localparam logic [7:0] COD_ADJ_BASE_BYTE = 8'h0A;

   // field positions in the first byte and the mode byte
   localparam int COD_W_BIT = 0;
   localparam int COD_D_BIT = 1;
   localparam int COD_S_BIT = 1;
   localparam int COD_MOD_LSB = 6;
   localparam int COD_REG_LSB = 3;
   localparam int COD_RM_LSB = 0;

   // mode field values, and the rm value that with mode 00 means a direct 16-bit address
   localparam logic [1:0] COD_MOD_NO_DISP = 2'b00;
   localparam logic [1:0] COD_MOD_DISP8 = 2'b01;
   localparam logic [1:0] COD_MOD_DISP16 = 2'b10;
   localparam logic [2:0] COD_RM_DIRECT = 3'b110;

   typedef enum logic [4:0] {
      OP_NONE = 5'h00, OP_TABLE_LOOKUP = 5'h01, OP_EA_LOAD = 5'h02,
      OP_FAR_DATA_SEG = 5'h03, OP_FAR_EXTRA_SEG = 5'h04,
      OP_FLAGS_TO_HIGH = 5'h05, OP_HIGH_TO_FLAGS = 5'h06,
      OP_FLAGS_SAVE = 5'h07, OP_FLAGS_RESTORE = 5'h08,
      OP_SUM = 5'h09, OP_CARRY_SUM = 5'h0A, OP_DIFFERENCE = 5'h0B,
      OP_BORROW_DIFF = 5'h0C, OP_COMPARE = 5'h0D,
      OP_ASCII_SUM = 5'h0E, OP_DECIMAL_SUM = 5'h0F,
      OP_ASCII_DIFF = 5'h10, OP_DECIMAL_DIFF = 5'h11,
      OP_UNSIGNED_PRODUCT = 5'h12, OP_SIGNED_PRODUCT = 5'h13,
      OP_UNSIGNED_QUOTIENT = 5'h14, OP_SIGNED_QUOTIENT = 5'h15,
      OP_ASCII_PRODUCT = 5'h16, OP_ASCII_QUOTIENT = 5'h17,
      OP_BYTE_TO_WORD = 5'h18, OP_WORD_TO_DOUBLE = 5'h19
   } cod_op_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_MODE = 3'b001, ST_DISP_LO = 3'b010,
      ST_DISP_HI = 3'b011, ST_IMM_LO = 3'b100, ST_IMM_HI = 3'b101,
      ST_CONST = 3'b110
   } cod_state_t;

   typedef struct packed {
      cod_state_t st;
      cod_op_t op;
      logic word;
      logic regIsDest;
      logic [1:0] mode;
      logic [2:0] regSel;
      logic [2:0] rmSel;
      logic [15:0] disp;
      logic [15:0] imm;
      logic widened;
      logic hasImm;
      logic immTwo;
      logic dispTwo;
      logic valid;
      logic illegal;
   } cod_regs_t;

   localparam cod_regs_t COD_REGS_RST = cod_regs_t'('0);

endpackage : cod_pkg

// ### verif/cod_decoder_tb.sv
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
   $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end

module cod_decoder_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import cod_pkg::*;

   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic inByteValid = 1'b0;
   logic [7:0] inByte = 8'h00;
   cod_op_t decOp;
   logic decValid, decIllegal, decWord, decRegIsDest, decImmWidened;
   logic [1:0] decMode;
   logic [2:0] decReg, decRm;
   logic [15:0] decDisp, decImm;
   int bad_count = 0;
   int cmp_count = 0;

   always #2 clk = ~clk;

   cod_decoder u_cod_decoder (.clk(clk), .sys_rst(sys_rst), .inByteValid(inByteValid), .inByte(inByte),
      .decOp(decOp), .decValid(decValid), .decIllegal(decIllegal), .decWord(decWord),
      .decRegIsDest(decRegIsDest), .decMode(decMode), .decReg(decReg), .decRm(decRm),
      .decDisp(decDisp), .decImm(decImm), .decImmWidened(decImmWidened));

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   // bytes are left-aligned in seq; the answer must land exactly one edge after the last byte
   task automatic run(input logic [31:0] seq, input int n, input logic ill);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         inByteValid <= 1'b1;
         inByte <= seq[31-8*i -: 8];
      end
      // the last byte is taken at this edge; the pulse stands only until the next one
      @(posedge clk);
      inByteValid <= 1'b0;
      #1;
      `CHK("valid", !ill, decValid)
      `CHK("illegal", ill, decIllegal)
   endtask : run

   task automatic t_single();
      logic [7:0] b[13] = '{8'hD7, 8'h9F, 8'h9E, 8'h9C, 8'h9D, 8'h37, 8'h27, 8'h3F, 8'h2F, 8'h98, 8'h99,
         8'hD4, 8'hD5};
      cod_op_t o[13] = '{OP_TABLE_LOOKUP, OP_FLAGS_TO_HIGH, OP_HIGH_TO_FLAGS, OP_FLAGS_SAVE,
         OP_FLAGS_RESTORE, OP_ASCII_SUM, OP_DECIMAL_SUM, OP_ASCII_DIFF, OP_DECIMAL_DIFF, OP_BYTE_TO_WORD,
         OP_WORD_TO_DOUBLE, OP_ASCII_PRODUCT, OP_ASCII_QUOTIENT};
      for (int i = 0; i < 13; i++)
      begin
         // the two ascii adjusts of products and quotients need the fixed base byte
         run({b[i], (i > 10) ? 8'h0A : 8'h00, 16'h0000}, (i > 10) ? 2 : 1, 1'b0);
         `CHK("op", o[i], decOp)
      end
      run(32'hD40B_0000, 2, 1'b1);
      run(32'hD50B_0000, 2, 1'b1);
      // a first byte outside the decoded set is refused at once
      run(32'hF400_0000, 1, 1'b1);
   endtask : t_single

   task automatic t_arith();
      logic [7:0] rb[5] = '{8'h00, 8'h10, 8'h28, 8'h18, 8'h38};
      logic [2:0] sf[5] = '{3'b000, 3'b010, 3'b101, 3'b011, 3'b111};
      cod_op_t o[5] = '{OP_SUM, OP_CARRY_SUM, OP_DIFFERENCE, OP_BORROW_DIFF, OP_COMPARE};
      for (int i = 0; i < 5; i++)
      begin
         run({rb[i] | 8'h03, 8'hD9, 16'h0000}, 2, 1'b0);
         `CHK("op", o[i], decOp)
         `CHK("word", 1'b1, decWord)
         `CHK("dest", 1'b1, decRegIsDest)
         `CHK("fields", 8'hD9, {decMode, decReg, decRm})
         run({rb[i], 8'h08, 16'h0000}, 2, 1'b0);
         `CHK("word", 1'b0, decWord)
         `CHK("dest", 1'b0, decRegIsDest)
         `CHK("reg", 3'b001, decReg)
         run({rb[i] | 8'h05, 24'h341200}, 3, 1'b0);
         `CHK("op", o[i], decOp)
         `CHK("imm", 16'h1234, decImm)
         run({rb[i] | 8'h04, 8'h7F, 16'h0000}, 2, 1'b0);
         `CHK("imm", 16'h007F, decImm)
         `CHK("word", 1'b0, decWord)
         run({8'h81, 8'hC0 | {2'b00, sf[i], 3'b000}, 16'h3412}, 4, 1'b0);
         `CHK("op", o[i], decOp)
         `CHK("imm", 16'h1234, decImm)
         `CHK("widened", 1'b0, decImmWidened)
         run({8'h80, 8'hC0 | {2'b00, sf[i], 3'b000}, 8'h85, 8'h00}, 3, 1'b0);
         `CHK("imm", 16'h0085, decImm)
         run({8'h83, 8'hC0 | {2'b00, sf[i], 3'b000}, 8'h80, 8'h00}, 3, 1'b0);
         `CHK("op", o[i], decOp)
         `CHK("imm", 16'hFF80, decImm)
         `CHK("widened", 1'b1, decImmWidened)
         `CHK("word", 1'b1, decWord)
      end
      // a sub-field outside the arithmetic set is refused after the mode byte
      run(32'h80C8_0000, 2, 1'b1);
   endtask : t_arith

   task automatic t_muldiv();
      cod_op_t o[4] = '{OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_UNSIGNED_QUOTIENT, OP_SIGNED_QUOTIENT};
      for (int i = 0; i < 4; i++)
      begin
         run({8'hF7, 2'b11, 3'(i + 4), 3'b010, 16'h0000}, 2, 1'b0);
         `CHK("op", o[i], decOp)
         `CHK("word", 1'b1, decWord)
         `CHK("rm", 3'b010, decRm)
      end
      run(32'hF6F8_0000, 2, 1'b0);
      `CHK("op", OP_SIGNED_QUOTIENT, decOp)
      `CHK("word", 1'b0, decWord)
      run(32'hF7C0_0000, 2, 1'b1);
   endtask : t_muldiv

   task automatic t_addr();
      run(32'h8D86_3412, 4, 1'b0);
      `CHK("op", OP_EA_LOAD, decOp)
      `CHK("dest", 1'b1, decRegIsDest)
      `CHK("fields", 8'h86, {decMode, decReg, decRm})
      `CHK("disp", 16'h1234, decDisp)
      run(32'hC54F_F000, 3, 1'b0);
      `CHK("op", OP_FAR_DATA_SEG, decOp)
      `CHK("disp", 16'hFFF0, decDisp)
      `CHK("reg", 3'b001, decReg)
      run(32'hC406_7856, 4, 1'b0);
      `CHK("op", OP_FAR_EXTRA_SEG, decOp)
      `CHK("disp", 16'h5678, decDisp)
   endtask : t_addr

   initial
   begin
      #20000;
      bad_count++;
      print_verdict();
   end

   initial
   begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      `CHK("rst op", OP_NONE, decOp)
      `CHK("rst valid", 1'b0, decValid)
      `CHK("rst imm", 16'h0000, decImm)
      t_single();
      t_arith();
      t_muldiv();
      t_addr();
      print_verdict();
   end
endmodule : cod_decoder_tb
